// >>> common/ser_group_if.sv
// signals between the register file and one event group
interface ser_group_if #(parameter int W = 16);
    logic [W-1:0] cond;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic [W-1:0] mask;
    logic [W-1:0] direct_set;
    logic         rd_clear;
    logic [W-1:0] event_bits;
    logic         summary;

    modport regs (
        output cond,
        output rise,
        output fall,
        output mask,
        output direct_set,
        output rd_clear,
        input  event_bits,
        input  summary
    );

    modport grp (
        input  cond,
        input  rise,
        input  fall,
        input  mask,
        input  direct_set,
        input  rd_clear,
        output event_bits,
        output summary
    );
endinterface

// >>> common/ser_pkg.sv
// constants for the status and event reporting block
// Notes on behaviour
// (R1) instrument reset: rising filters pass all bits
// (R2) after reset falling filters read zero
// (R3) independent rising and falling enables per bit
// (R4) writing zero disables that direction for all
// (R5) filters and masks written as binary weights
// (R6) masked questionable events drive status bit 3
// (R7) operation registers sixteen bits, same positions
// (R8) condition bit 3 while module busy
// (R9) condition bit 4 while gate on
// (R10) bit 5 unsupported command, event only
// (R11) bit 7 on user gate abort
// (R12) bit 8 on detected bit error
// (R13) bit 9 when repetitive period ends
// (R14) bits 11-13 show alignment activity
// (R15) condition register is live, not latched
// (R16) event bits latch until cleared
// (R17) masked operation events drive status bit 7
// (R18) unused bits never set, read zero
// (R19) event read returns contents then clears
// (R20) questionable condition bits 0,3,5,8,9,10
// (R21) clock loss summary feeds bits 5 and 9
// (R22) status bit 6 summarises enabled summaries
package ser_pkg;
    localparam int          GRP_W            = 16;
    localparam int          SEL_W            = 4;
    localparam int          SB_W             = 8;

    localparam logic [15:0] QUES_USED        = 16'h0729;
    localparam logic [15:0] OPER_USED        = 16'h3bb8;
    localparam logic [15:0] OPER_COND_USED   = 16'h3b98;

    localparam int          QUES_DATA_LOSS   = 0;
    localparam int          QUES_POWER_LOSS  = 3;
    localparam int          QUES_CLK_LOSS_A  = 5;
    localparam int          QUES_CAL_MISM    = 8;
    localparam int          QUES_CLK_LOSS_B  = 9;
    localparam int          QUES_SYNC_LOSS   = 10;

    localparam int          OPER_MOD_BUSY    = 3;
    localparam int          OPER_GATE_ON     = 4;
    localparam int          OPER_UNSUPP      = 5;
    localparam int          OPER_GATE_ABORT  = 7;
    localparam int          OPER_BIT_ERR     = 8;
    localparam int          OPER_GATE_END    = 9;
    localparam int          OPER_CLK_DATA    = 11;
    localparam int          OPER_THRESH      = 12;
    localparam int          OPER_AUTO_ALIGN  = 13;

    localparam int          SB_QUES          = 3;
    localparam int          SB_MASTER        = 6;
    localparam int          SB_OPER          = 7;

    localparam logic [15:0] QUES_RISE_RST    = QUES_USED;
    localparam logic [15:0] OPER_RISE_RST    = OPER_USED;
    localparam logic [15:0] FALL_RST         = 16'h0000;
    localparam logic [15:0] MASK_RST         = 16'h0000;

    localparam logic [3:0]  SEL_QUES_COND    = 4'h0;
    localparam logic [3:0]  SEL_QUES_EVENT   = 4'h1;
    localparam logic [3:0]  SEL_QUES_RISE    = 4'h2;
    localparam logic [3:0]  SEL_QUES_FALL    = 4'h3;
    localparam logic [3:0]  SEL_QUES_MASK    = 4'h4;
    localparam logic [3:0]  SEL_OPER_COND    = 4'h5;
    localparam logic [3:0]  SEL_OPERATION_EVENT   = 4'h6;
    localparam logic [3:0]  SEL_OPER_RISE    = 4'h7;
    localparam logic [3:0]  SEL_OPER_FALL    = 4'h8;
    localparam logic [3:0]  SEL_OPER_MASK    = 4'h9;
endpackage

// >>> rtl/ser_event_group.sv
// transition filter, latched event register and masked summary
module ser_event_group #(
    parameter int           W    = 16,
    parameter logic [W-1:0] USED = '1
) (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    input  wire logic ce_in,
    ser_group_if.grp  g
);
    logic [W-1:0] prev_cond;
    logic [W-1:0] event_q;
    logic [W-1:0] rise_hit;
    logic [W-1:0] fall_hit;
    logic [W-1:0] next_set;

    // per bit edge detect, each direction gated on its own
    assign rise_hit = g.cond & ~prev_cond & g.rise; // R3
    assign fall_hit = ~g.cond & prev_cond & g.fall; // R3
    assign next_set = (rise_hit | fall_hit | g.direct_set) & USED; // R18

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_cond <= '0;
        end else if (ce_in) begin
            prev_cond <= g.cond;
        end
    end

    // set wins over read clear so no event is lost
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            event_q <= '0;
        end else if (ce_in) begin
            event_q <= (event_q & ~{W{g.rd_clear}}) | next_set; // R16 R19
        end
    end

    assign g.event_bits = event_q;
    assign g.summary    = |(event_q & g.mask);
endmodule

// >>> rtl/ser_status_top.sv
// status reporting: questionable and operation groups, command port
module ser_status_top (
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    input  wire logic        inst_reset_in,
    input  wire logic [3:0]  reg_sel_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic [7:0]  srq_enable_in,
    input  wire logic        data_loss_in,
    input  wire logic        power_loss_in,
    input  wire logic        clock_loss_sum_in,
    input  wire logic        calibration_mismatch_in,
    input  wire logic        sync_loss_in,
    input  wire logic        module_busy_flag_in,
    input  wire logic        gate_on_in,
    input  wire logic        unsupported_command_flag_in,
    input  wire logic        gate_abort_in,
    input  wire logic        bit_error_in,
    input  wire logic        gate_end_in,
    input  wire logic        clock_data_centring_in,
    input  wire logic        threshold_centring_in,
    input  wire logic        auto_align_in,
    output logic [15:0]      rd_data_out,
    output logic             rd_valid_out,
    output logic             cmd_error_out,
    output logic [7:0]       status_byte_out
);
    logic [15:0] ques_cond;
    logic [15:0] oper_cond;
    logic [15:0] ques_rise;
    logic [15:0] ques_fall;
    logic [15:0] ques_mask;
    logic [15:0] oper_rise;
    logic [15:0] oper_fall;
    logic [15:0] oper_mask;
    logic [15:0] next_ques_cond;
    logic [15:0] next_oper_cond;
    logic [15:0] oper_direct;
    logic [15:0] wr_q;
    logic [15:0] wr_o;
    logic [15:0] next_rd;
    logic        next_err;
    logic        sel_known;
    logic        sel_ro;
    logic        do_wr;
    logic        do_rd;
    logic [7:0]  next_sb;

    ser_group_if #(.W(ser_pkg::GRP_W)) ques_if ();
    ser_group_if #(.W(ser_pkg::GRP_W)) oper_if ();

    // live condition images, no latching
    always_comb begin
        next_ques_cond = '0;
        next_ques_cond[ser_pkg::QUES_DATA_LOSS]  = data_loss_in; // R20
        next_ques_cond[ser_pkg::QUES_POWER_LOSS] = power_loss_in; // R20
        next_ques_cond[ser_pkg::QUES_CLK_LOSS_A] = clock_loss_sum_in; // R21
        next_ques_cond[ser_pkg::QUES_CAL_MISM]   = calibration_mismatch_in;
        next_ques_cond[ser_pkg::QUES_CLK_LOSS_B] = clock_loss_sum_in; // R21
        next_ques_cond[ser_pkg::QUES_SYNC_LOSS]  = sync_loss_in; // R20
    end

    always_comb begin
        next_oper_cond = '0;
        next_oper_cond[ser_pkg::OPER_MOD_BUSY]   = module_busy_flag_in; // R8
        next_oper_cond[ser_pkg::OPER_GATE_ON]    = gate_on_in; // R9
        next_oper_cond[ser_pkg::OPER_GATE_ABORT] = gate_abort_in; // R11
        next_oper_cond[ser_pkg::OPER_BIT_ERR]    = bit_error_in; // R12
        next_oper_cond[ser_pkg::OPER_GATE_END]   = gate_end_in; // R13
        next_oper_cond[ser_pkg::OPER_CLK_DATA]   = clock_data_centring_in;
        next_oper_cond[ser_pkg::OPER_THRESH]     = threshold_centring_in;
        next_oper_cond[ser_pkg::OPER_AUTO_ALIGN] = auto_align_in; // R14
    end

    // one stage keeps the filter edge and the readback in step
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ques_cond <= '0;
            oper_cond <= '0;
        end else if (ce_in) begin
            ques_cond <= next_ques_cond & ser_pkg::QUES_USED; // R15
            oper_cond <= next_oper_cond & ser_pkg::OPER_COND_USED; // R15
        end
    end

    // unsupported command has no condition, it goes straight in
    always_comb begin
        oper_direct = '0;
        oper_direct[ser_pkg::OPER_UNSUPP] = unsupported_command_flag_in; // R10
    end

    // command decode; a read and a write together is refused
    assign do_wr = wr_en_in && !rd_en_in;
    assign do_rd = rd_en_in && !wr_en_in;

    always_comb begin
        sel_known = 1'b1;
        sel_ro    = 1'b0;
        unique case (reg_sel_in)
            ser_pkg::SEL_QUES_COND,
            ser_pkg::SEL_QUES_EVENT,
            ser_pkg::SEL_OPER_COND,
            ser_pkg::SEL_OPERATION_EVENT: begin
                sel_ro = 1'b1;
            end
            ser_pkg::SEL_QUES_RISE,
            ser_pkg::SEL_QUES_FALL,
            ser_pkg::SEL_QUES_MASK,
            ser_pkg::SEL_OPER_RISE,
            ser_pkg::SEL_OPER_FALL,
            ser_pkg::SEL_OPER_MASK: begin
                sel_ro = 1'b0;
            end
            default: begin
                sel_known = 1'b0;
            end
        endcase
    end

    // weights summed by the controller land bit for bit
    assign wr_q = wr_data_in & ser_pkg::QUES_USED; // R5 R18
    assign wr_o = wr_data_in & ser_pkg::OPER_USED; // R5 R7 R18

    // filters: instrument reset restores rising and clears falling
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ques_rise <= ser_pkg::QUES_RISE_RST; // R1
            ques_fall <= ser_pkg::FALL_RST; // R2
        end else if (ce_in) begin
            if (inst_reset_in) begin
                ques_rise <= ser_pkg::QUES_RISE_RST; // R1
                ques_fall <= ser_pkg::FALL_RST; // R2
            end else if (do_wr && reg_sel_in == ser_pkg::SEL_QUES_RISE) begin
                ques_rise <= wr_q; // R4
            end else if (do_wr && reg_sel_in == ser_pkg::SEL_QUES_FALL) begin
                ques_fall <= wr_q; // R4
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oper_rise <= ser_pkg::OPER_RISE_RST; // R1
            oper_fall <= ser_pkg::FALL_RST; // R2
        end else if (ce_in) begin
            if (inst_reset_in) begin
                oper_rise <= ser_pkg::OPER_RISE_RST; // R1
                oper_fall <= ser_pkg::FALL_RST; // R2
            end else if (do_wr && reg_sel_in == ser_pkg::SEL_OPER_RISE) begin
                oper_rise <= wr_o; // R4
            end else if (do_wr && reg_sel_in == ser_pkg::SEL_OPER_FALL) begin
                oper_fall <= wr_o; // R4
            end
        end
    end

    // masks survive an instrument reset, only power-up clears them
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ques_mask <= ser_pkg::MASK_RST;
            oper_mask <= ser_pkg::MASK_RST;
        end else if (ce_in) begin
            if (do_wr && reg_sel_in == ser_pkg::SEL_QUES_MASK) begin
                ques_mask <= wr_q; // R6
            end
            if (do_wr && reg_sel_in == ser_pkg::SEL_OPER_MASK) begin
                oper_mask <= wr_o; // R17
            end
        end
    end

    assign ques_if.cond       = ques_cond;
    assign ques_if.rise       = ques_rise;
    assign ques_if.fall       = ques_fall;
    assign ques_if.mask       = ques_mask;
    assign ques_if.direct_set = '0;
    assign ques_if.rd_clear   = ce_in && do_rd &&
                                reg_sel_in == ser_pkg::SEL_QUES_EVENT; // R19

    assign oper_if.cond       = oper_cond;
    assign oper_if.rise       = oper_rise;
    assign oper_if.fall       = oper_fall;
    assign oper_if.mask       = oper_mask;
    assign oper_if.direct_set = oper_direct;
    assign oper_if.rd_clear   = ce_in && do_rd &&
                                reg_sel_in == ser_pkg::SEL_OPERATION_EVENT; // R19

    ser_event_group #(
        .W    (ser_pkg::GRP_W),
        .USED (ser_pkg::QUES_USED)
    ) u_ques (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .ce_in      (ce_in),
        .g          (ques_if)
    );

    ser_event_group #(
        .W    (ser_pkg::GRP_W),
        .USED (ser_pkg::OPER_USED)
    ) u_oper (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .ce_in      (ce_in),
        .g          (oper_if)
    );

    // read mux; event contents are taken before their clear lands
    always_comb begin
        next_rd = '0;
        unique case (reg_sel_in)
            ser_pkg::SEL_QUES_COND:  next_rd = ques_cond;
            ser_pkg::SEL_QUES_EVENT: next_rd = ques_if.event_bits; // R19
            ser_pkg::SEL_QUES_RISE:  next_rd = ques_rise;
            ser_pkg::SEL_QUES_FALL:  next_rd = ques_fall;
            ser_pkg::SEL_QUES_MASK:  next_rd = ques_mask;
            ser_pkg::SEL_OPER_COND:  next_rd = oper_cond;
            ser_pkg::SEL_OPERATION_EVENT: next_rd = oper_if.event_bits; // R19
            ser_pkg::SEL_OPER_RISE:  next_rd = oper_rise;
            ser_pkg::SEL_OPER_FALL:  next_rd = oper_fall;
            ser_pkg::SEL_OPER_MASK:  next_rd = oper_mask;
            default:                 next_rd = '0;
        endcase
    end

    // error: unknown select, write to read-only, or both strobes
    always_comb begin
        next_err = 1'b0;
        if (wr_en_in && rd_en_in) begin
            next_err = 1'b1;
        end else if ((wr_en_in || rd_en_in) && !sel_known) begin
            next_err = 1'b1;
        end else if (wr_en_in && sel_ro) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out   <= '0;
            rd_valid_out  <= 1'b0;
            cmd_error_out <= 1'b0;
        end else if (ce_in) begin
            rd_valid_out  <= do_rd && sel_known;
            cmd_error_out <= next_err;
            if (do_rd && sel_known) begin
                rd_data_out <= next_rd;
            end
        end
    end

    // status byte summary bits; master bit follows enabled summaries
    always_comb begin
        next_sb = '0;
        next_sb[ser_pkg::SB_QUES]   = ques_if.summary; // R6
        next_sb[ser_pkg::SB_OPER]   = oper_if.summary; // R17
        next_sb[ser_pkg::SB_MASTER] =
            (ques_if.summary && srq_enable_in[ser_pkg::SB_QUES]) ||
            (oper_if.summary && srq_enable_in[ser_pkg::SB_OPER]); // R22
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_byte_out <= '0;
        end else if (ce_in) begin
            status_byte_out <= next_sb;
        end
    end
endmodule

// >>> testbench/ser_ctrl_model.sv
// remote controller model issuing status commands
module ser_ctrl_model (
    input  wire logic        sys_clk_in,
    output logic [3:0]       reg_sel_out,
    output logic             wr_en_out,
    output logic             rd_en_out,
    output logic [15:0]      wr_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_sel_out = 4'h0;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        wr_data_out = 16'h0000;
    end
    // gap lets the controller be prompt or slow
    task automatic cmd(input logic r, input logic w, input logic [3:0] s,
                       input logic [15:0] d, input int gap);
        repeat (gap) @(negedge sys_clk_in);
        @(negedge sys_clk_in);
        rd_en_out = r;
        wr_en_out = w;
        reg_sel_out = s;
        wr_data_out = d;
        @(negedge sys_clk_in);
        rd_en_out = 1'b0;
        wr_en_out = 1'b0;
        // released lines show junk, not the last value
        reg_sel_out = ~s;
        wr_data_out = ~d;
    endtask
endmodule

// >>> testbench/ser_status_props.sv
// checker: read answers, refusals, filter reset and status byte
module ser_status_props (
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    input  wire logic        inst_reset_in,
    input  wire logic [3:0]  reg_sel_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    input  wire logic        module_busy_flag_in,
    input  wire logic [15:0] rd_data_out,
    input  wire logic        rd_valid_out,
    input  wire logic        cmd_error_out,
    input  wire logic [7:0]  status_byte_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic rd;
    logic bad;
    assign rd = ce_in && rd_en_in && !wr_en_in;
    assign bad = reg_sel_in > 4'h9;
    a_read_answered: assert property (rd && !bad |=> rd_valid_out)
        else $error("read not answered");
    a_no_answer: assert property (ce_in && !rd_en_in |=> !rd_valid_out)
        else $error("answer without read");
    a_both_refused: assert property (ce_in && rd_en_in && wr_en_in
        |=> cmd_error_out && !rd_valid_out) else $error("clash accepted");
    a_sel_refused: assert property (rd && bad
        |=> cmd_error_out && !rd_valid_out) else $error("bad select read");
    a_data_holds: assert property ($changed(rd_data_out) |-> rd_valid_out)
        else $error("read data moved");
    a_fall_cleared: assert property (ce_in && inst_reset_in ##1 rd &&
        reg_sel_in == ser_pkg::SEL_OPER_FALL |=> rd_data_out == 16'h0000)
        else $error("fall filter not cleared");
    a_rise_restored: assert property (ce_in && inst_reset_in ##1 rd &&
        reg_sel_in == ser_pkg::SEL_OPER_RISE
        |=> rd_data_out == ser_pkg::OPER_RISE_RST)
        else $error("rise filter not restored");
    a_cond_unused: assert property (rd && reg_sel_in == 4'h5
        |=> (rd_data_out & 16'hc467) == 16'h0000)
        else $error("unused condition bit");
    a_busy_shown: assert property (ce_in && module_busy_flag_in ##1 rd &&
        reg_sel_in == 4'h5 |=> rd_data_out[3]) else $error("busy not shown");
    a_sb_unused: assert property (status_byte_out[5:4] == 2'b00 &&
        status_byte_out[2:0] == 3'b000) else $error("status byte bit");
endmodule

// >>> testbench/ser_status_test.sv
// testbench: both status groups driven by a controller model
module ser_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        inst_reset_in = 1'b0;
    logic        ce_in = 1'b1;
    logic [7:0]  sre = 8'h88;
    logic [15:0] oc = 16'h0000;
    logic [15:0] qc = 16'h0000;
    logic [3:0]  reg_sel_in;
    logic        wr_en_in;
    logic        rd_en_in;
    logic [15:0] wr_data_in;
    logic [15:0] rd_data_out;
    logic        rd_valid_out;
    logic        cmd_error_out;
    logic [7:0]  status_byte_out;
    logic [16:0] q[$];
    logic [15:0] v;
    int          n_fail = 0;
    int          n_tests = 0;
    localparam logic [15:0] RST_TAB [10] = '{16'h0, 16'h0,
        ser_pkg::QUES_RISE_RST, 16'h0, 16'h0, 16'h0, 16'h0,
        ser_pkg::OPER_RISE_RST, 16'h0, 16'h0};

    always #20 sys_clk_in = ~sys_clk_in;

    ser_ctrl_model mdl (.sys_clk_in(sys_clk_in), .reg_sel_out(reg_sel_in),
        .wr_en_out(wr_en_in), .rd_en_out(rd_en_in),
        .wr_data_out(wr_data_in));

    ser_status_top DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .ce_in(ce_in), .inst_reset_in(inst_reset_in), .reg_sel_in(reg_sel_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wr_data_in(wr_data_in),
        .srq_enable_in(sre), .data_loss_in(qc[0]),
        .power_loss_in(qc[3]), .clock_loss_sum_in(qc[5]),
        .calibration_mismatch_in(qc[8]), .sync_loss_in(qc[10]),
        .module_busy_flag_in(oc[3]), .gate_on_in(oc[4]),
        .unsupported_command_flag_in(oc[5]), .gate_abort_in(oc[7]),
        .bit_error_in(oc[8]), .gate_end_in(oc[9]),
        .clock_data_centring_in(oc[11]), .threshold_centring_in(oc[12]),
        .auto_align_in(oc[13]), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .cmd_error_out(cmd_error_out),
        .status_byte_out(status_byte_out));

    task automatic fail(input string m);
        n_fail++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        n_tests++;
        if (g !== e) fail($sformatf("bus result %h expected %h", g, e));
    endtask
    task automatic chk_sb(input logic [7:0] e);
        n_tests++;
        if (status_byte_out !== e) fail("status byte");
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task automatic rd(input logic [3:0] s, input logic [15:0] e);
        q.push_back({1'b0, e});
        mdl.cmd(1'b1, 1'b0, s, 16'h0000, $urandom_range(1, 0));
    endtask
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        mdl.cmd(1'b0, 1'b1, s, d, 0);
    endtask
    task automatic bad(input logic r, input logic w, input logic [3:0] s);
        q.push_back(17'h10000);
        mdl.cmd(r, w, s, 16'hffff, 0);
    endtask
    task automatic test_done;
        if (q.size() != 0) fail("results missing");
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // results are one-cycle pulses, so look every cycle
    always @(negedge sys_clk_in) begin
        if (rd_valid_out === 1'b1 || cmd_error_out === 1'b1) begin
            if (q.size() == 0)
                fail("unexpected result");
            else
                chk({cmd_error_out, rd_data_out & {16{rd_valid_out}}},
                    q.pop_front());
        end
    end

    initial begin
        #100000;
        fail("timeout");
        test_done();
    end

    initial begin
        void'($urandom(66));
        tick(10);
        rstn_in = 1'b1;
        for (int i = 0; i < 10; i++) rd(i[3:0], RST_TAB[i]);
        for (int s = 10; s < 16; s++) bad(1'b1, 1'b0, s[3:0]);
        bad(1'b1, 1'b1, ser_pkg::SEL_OPER_MASK);
        bad(1'b0, 1'b1, ser_pkg::SEL_OPER_COND);
        bad(1'b0, 1'b1, ser_pkg::SEL_QUES_EVENT);
        rd(ser_pkg::SEL_OPER_MASK, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            wr(ser_pkg::SEL_OPER_RISE, v);
            rd(ser_pkg::SEL_OPER_RISE, v & 16'h3bb8);
            wr(ser_pkg::SEL_QUES_MASK, v);
            rd(ser_pkg::SEL_QUES_MASK, v & 16'h0729);
        end
        wr(ser_pkg::SEL_OPER_RISE, 16'h0000);
        wr(ser_pkg::SEL_QUES_RISE, 16'h0000);
        wr(ser_pkg::SEL_QUES_MASK, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            oc = 16'($urandom) & 16'hffdf;
            qc = 16'($urandom);
            rd(4'h5, oc & 16'h3b98);
            rd(4'h0, (qc & 16'h0529) | {6'h0, qc[5], 9'h0});
        end
        oc = 16'h0000;
        qc = 16'h0000;
        rd(ser_pkg::SEL_OPERATION_EVENT, 16'h0000);
        rd(ser_pkg::SEL_QUES_EVENT, 16'h0000);
        wr(ser_pkg::SEL_OPER_RISE, 16'h0200);
        wr(ser_pkg::SEL_OPER_MASK, 16'h0280);
        oc[9] = 1'b1;
        tick(1);
        oc[9] = 1'b0;
        tick(4);
        chk_sb(8'hc0);
        rd(ser_pkg::SEL_OPERATION_EVENT, 16'h0200);
        rd(ser_pkg::SEL_OPERATION_EVENT, 16'h0000);
        tick(3);
        chk_sb(8'h00);
        wr(ser_pkg::SEL_OPER_FALL, 16'h0010);
        oc[4] = 1'b1;
        tick(3);
        rd(ser_pkg::SEL_OPERATION_EVENT, 16'h0000);
        oc[4] = 1'b0;
        tick(3);
        chk_sb(8'h00);
        rd(ser_pkg::SEL_OPERATION_EVENT, 16'h0010);
        oc[5] = 1'b1;
        tick(1);
        oc[5] = 1'b0;
        rd(ser_pkg::SEL_OPERATION_EVENT, 16'h0020);
        wr(ser_pkg::SEL_QUES_RISE, 16'h0020);
        wr(ser_pkg::SEL_QUES_MASK, 16'h0028);
        qc[5] = 1'b1;
        tick(5);
        chk_sb(8'h48);
        // master bit must drop once its enable is taken away
        sre = 8'h80;
        tick(1);
        chk_sb(8'h08);
        sre = 8'h88;
        rd(ser_pkg::SEL_QUES_EVENT, 16'h0020);
        qc[5] = 1'b0;
        wr(ser_pkg::SEL_OPER_FALL, 16'hffff);
        inst_reset_in = 1'b1;
        rd(ser_pkg::SEL_OPER_RISE, ser_pkg::OPER_RISE_RST);
        rd(ser_pkg::SEL_OPER_FALL, 16'h0000);
        rd(ser_pkg::SEL_QUES_RISE, ser_pkg::QUES_RISE_RST);
        inst_reset_in = 1'b0;
        rd(ser_pkg::SEL_OPER_MASK, 16'h0280);
        // let the last answer pulse die, a frozen pulse would repeat
        tick(1);
        ce_in = 1'b0;
        wr(ser_pkg::SEL_OPER_MASK, 16'h0000);
        ce_in = 1'b1;
        rd(ser_pkg::SEL_OPER_MASK, 16'h0280);
        tick(4);
        test_done();
    end
endmodule

bind ser_status_top ser_status_props u_props (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .ce_in(ce_in), .inst_reset_in(inst_reset_in),
    .reg_sel_in(reg_sel_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .module_busy_flag_in(module_busy_flag_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .cmd_error_out(cmd_error_out),
    .status_byte_out(status_byte_out));
